/* File: rtl/pbc_pkg.sv */
// Purpose: Shared constants and types of the PLL bandwidth and base clock select block.
// Assumes: One AHB-Lite slave, 32-bit data, three word registers.
// Notes:   Field positions, offsets and the programming reset value live here; control reset values are set in pbc_top.
package pbc_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_BANDWIDTH = 8'h04;
   localparam logic [7:0] ADDR_PROGRAM   = 8'h08;

   // Control register fields.
   localparam int CTL_IE_BIT   = 7;
   localparam int CTL_FLAG_BIT = 6;
   localparam int CTL_EN_BIT   = 5;
   localparam int CTL_BCS_BIT  = 4;
   localparam logic [3:0] CTL_UNUSED_READ = 4'hf;

   // Bandwidth register fields.
   localparam int BW_AUTO_BIT  = 7;
   localparam int BW_LOCK_BIT  = 6;
   localparam int BW_TRACK_BIT = 5;

   // Programming register fields.
   localparam int PRG_MUL_LSB   = 4;
   localparam int PRG_RANGE_LSB = 0;
   localparam logic [7:0] PRG_RESET = 8'h11;

   // ************************************************************
   // Lock detector and base clock switch timing
   // ************************************************************
   localparam int WIN_REF_EDGES = 32;
   localparam int LOCK_TOL      = 1;
   localparam int UNLOCK_TOL    = 2;
   localparam int TRK_TOL       = 2;
   localparam int UNT_TOL       = 4;
   localparam logic [1:0] SWITCH_EDGES = 2'h3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic ie;
      logic flag;
      logic en;
      logic base_clock_select;
   } pbc_ctrl_type;

   typedef struct packed {
      logic       auto_bw;
      logic       track_man;
      logic [3:0] mul;
      logic [3:0] range;
   } pbc_cfg_type;

   typedef enum logic [0:0] {
      SW_RUN  = 1'b0,
      SW_WAIT = 1'b1
   } pbc_sw_state_type;

endpackage

/* File: rtl/pbc_top.sv */
// Purpose: Control logic of a PLL clock generator: bandwidth modes, lock detection,
//          programming decode and glitch-free base clock selection.
// Assumes: crystal_clock and vco_clock are slower than hclk and are sampled as levels.
// Notes:   Registers are reached over AHB-Lite; reads take one wait state.
// Operation
// - Automatic mode: lock detector switches filter acquisition/tracking by itself.
// - Automatic mode: tracking bit read-only, set within track, cleared past untrack.
// - Automatic mode: lock bit read-only, set within lock, cleared past unlock tolerance.
// - Automatic mode: each lock toggle raises interrupt request when enabled.
// - Manual mode: tracking bit is writable and drives the filter mode directly.
// - Manual mode: lock indicator disabled, no interrupts issued.
// - Programming register: multiplier in upper four bits, range in lower four.
// - Multiplier zero behaves as one.
// - Range zero disables the PLL and forces the crystal clock.
// - Source change waits three crystal and three VCO edges (VCO edges waived while the PLL is off), output held.
// - Selected source divided by two for a balanced base clock.
// - VCO selection refused while PLL enable is clear.
// - PLL enable cannot be cleared while the VCO is selected.
// - One write cannot both change PLL enable and change the selection.
// - Feedback divider divides VCO clock by multiplier before comparison.
// - Tracking bit reads zero in acquisition, one in tracking.
// - A read of the control register clears the lock change flag unless a lock toggle sets it in the same cycle.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module pbc_top #(
   parameter int WIN       = pbc_pkg::WIN_REF_EDGES,
   parameter int LOCK_T    = pbc_pkg::LOCK_TOL,
   parameter int UNLOCK_T  = pbc_pkg::UNLOCK_TOL,
   parameter int TRK_T     = pbc_pkg::TRK_TOL,
   parameter int UNT_T     = pbc_pkg::UNT_TOL
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Clock sources from the analog side
   input  wire logic        crystal_clock,
   input  wire logic        vco_clock,
   // Controls toward the analog side
   output logic             pll_power_on,
   output logic             loop_filter_track,
   output logic      [3:0]  vco_range,
   output logic      [3:0]  feedback_multiplier,
   // Clock and event outputs
   output logic             base_clock_out,
   output logic             lock_irq
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [2:0] xs_q, xs_d;
   logic [2:0] vs_q, vs_d;
   logic       x_rise, v_rise;

   always_comb begin
      xs_d = {xs_q[1:0], crystal_clock};
      vs_d = {vs_q[1:0], vco_clock};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xs_q <= 3'h0;
         vs_q <= 3'h0;
      end else begin
         xs_q <= xs_d;
         vs_q <= vs_d;
      end
   end

   assign x_rise = xs_q[1] & ~xs_q[2];
   assign v_rise = vs_q[1] & ~vs_q[2];

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic       wr_pend_q, wr_pend_d;
   logic       rd_pend_q, rd_pend_d;
   logic [7:0] addr_q, addr_d;
   logic [7:0] rdata_q, rdata_d;
   logic       accept;
   logic       wr_ctl, wr_bw, wr_prg, rd_ctl;
   logic [7:0] wd;
   logic [7:0] rd_mux;

   pbc_pkg::pbc_ctrl_type ctl_q, ctl_d;
   pbc_pkg::pbc_cfg_type  cfg_q, cfg_d;
   logic                  lock_q, lock_d;
   logic                  trk_q, trk_d;

   // Reads stall one cycle because the read data is registered from rd_mux before it drives hrdata.
   assign hreadyout = ~rd_pend_q;
   assign hresp     = 1'b0;
   assign hrdata    = {24'h000000, rdata_q};
   assign accept    = hsel & htrans[1] & hready;
   assign wd        = hwdata[7:0];
   assign wr_ctl    = wr_pend_q & (addr_q == pbc_pkg::ADDR_CONTROL);
   assign wr_bw     = wr_pend_q & (addr_q == pbc_pkg::ADDR_BANDWIDTH);
   assign wr_prg    = wr_pend_q & (addr_q == pbc_pkg::ADDR_PROGRAM);
   assign rd_ctl    = rd_pend_q & (addr_q == pbc_pkg::ADDR_CONTROL);

   always_comb begin
      rd_mux = 8'h00;
      case (addr_q)
         pbc_pkg::ADDR_CONTROL: begin
            rd_mux[pbc_pkg::CTL_IE_BIT]   = ctl_q.ie & cfg_q.auto_bw;
            rd_mux[pbc_pkg::CTL_FLAG_BIT] = ctl_q.flag & cfg_q.auto_bw;
            rd_mux[pbc_pkg::CTL_EN_BIT]   = ctl_q.en;
            rd_mux[pbc_pkg::CTL_BCS_BIT]  = ctl_q.base_clock_select;
            rd_mux[3:0]                   = pbc_pkg::CTL_UNUSED_READ;
         end
         pbc_pkg::ADDR_BANDWIDTH: begin
            rd_mux[pbc_pkg::BW_AUTO_BIT]  = cfg_q.auto_bw;
            rd_mux[pbc_pkg::BW_LOCK_BIT]  = lock_q & cfg_q.auto_bw;
            rd_mux[pbc_pkg::BW_TRACK_BIT] = loop_filter_track;
         end
         pbc_pkg::ADDR_PROGRAM: begin
            rd_mux = {cfg_q.mul, cfg_q.range};
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always_comb begin
      wr_pend_d = accept & hwrite;
      rd_pend_d = accept & ~hwrite;
      addr_d    = accept ? haddr[7:0] : addr_q;
      rdata_d   = rd_pend_q ? rd_mux : rdata_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
         rdata_q   <= 8'h00;
      end else begin
         wr_pend_q <= wr_pend_d;
         rd_pend_q <= rd_pend_d;
         addr_q    <= addr_d;
         rdata_q   <= rdata_d;
      end
   end

   // ************************************************************
   // Control and configuration registers
   // ************************************************************
   logic range_ok;
   logic lock_toggle;

   assign range_ok    = (cfg_q.range != 4'h0);
   assign lock_toggle = lock_d ^ lock_q;

   always_comb begin
      ctl_d = ctl_q;
      cfg_d = cfg_q;
      if (wr_ctl) begin
         if (cfg_q.auto_bw) begin
            ctl_d.ie = wd[pbc_pkg::CTL_IE_BIT];
         end
         // Enable looks at the old selection and selection compares old and new enable, so one write never moves both.
         ctl_d.en  = wd[pbc_pkg::CTL_EN_BIT] | ctl_q.base_clock_select;
         ctl_d.base_clock_select = wd[pbc_pkg::CTL_BCS_BIT] & ctl_q.en & ctl_q.en == ctl_d.en
                     & range_ok;
      end
      if (rd_ctl) begin
         ctl_d.flag = 1'b0;
      end
      if (cfg_q.auto_bw && lock_toggle) begin
         ctl_d.flag = 1'b1;
      end
      if (!range_ok) begin
         ctl_d.base_clock_select = 1'b0;
      end
      if (wr_bw) begin
         cfg_d.auto_bw = wd[pbc_pkg::BW_AUTO_BIT];
         if (!cfg_q.auto_bw) begin
            cfg_d.track_man = wd[pbc_pkg::BW_TRACK_BIT];
         end
      end
      if (wr_prg) begin
         cfg_d.mul   = wd[pbc_pkg::PRG_MUL_LSB +: 4];
         cfg_d.range = wd[pbc_pkg::PRG_RANGE_LSB +: 4];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_q <= '{ie: 1'b0, flag: 1'b0, en: 1'b1, base_clock_select: 1'b0};
         cfg_q <= '{auto_bw: 1'b0, track_man: 1'b0,
                    mul: pbc_pkg::PRG_RESET[7:4], range: pbc_pkg::PRG_RESET[3:0]};
      end else begin
         ctl_q <= ctl_d;
         cfg_q <= cfg_d;
      end
   end

   assign pll_power_on        = ctl_q.en & range_ok;
   assign vco_range           = cfg_q.range;
   assign feedback_multiplier = (cfg_q.mul == 4'h0) ? 4'h1 : cfg_q.mul;
   assign loop_filter_track   = cfg_q.auto_bw ? trk_q : cfg_q.track_man;
   assign lock_irq            = ctl_q.flag & ctl_q.ie & cfg_q.auto_bw;

   // ************************************************************
   // Feedback divider and lock detector
   // ************************************************************
   logic [3:0] fb_cnt_q, fb_cnt_d;
   logic       fb_pulse;
   logic [7:0] win_q, win_d;
   logic [7:0] fbw_q, fbw_d;
   logic [7:0] diff;
   logic       win_end;
   logic       det_on;

   assign det_on   = pll_power_on & cfg_q.auto_bw;
   assign fb_pulse = v_rise & (fb_cnt_q == feedback_multiplier - 4'h1);
   assign win_end  = x_rise & (win_q == 8'(WIN - 1));
   assign diff     = (fbw_q > 8'(WIN)) ? fbw_q - 8'(WIN) : 8'(WIN) - fbw_q;

   always_comb begin
      fb_cnt_d = fb_cnt_q;
      win_d    = win_q;
      fbw_d    = fbw_q;
      lock_d   = lock_q;
      trk_d    = trk_q;
      if (v_rise) begin
         fb_cnt_d = fb_pulse ? 4'h0 : fb_cnt_q + 4'h1;
      end
      if (fb_pulse) begin
         fbw_d = fbw_q + 8'h01;
      end
      if (x_rise) begin
         win_d = win_end ? 8'h00 : win_q + 8'h01;
      end
      if (win_end) begin
         fbw_d = 8'h00;
         // Hysteresis: set and clear thresholds differ.
         if (diff <= 8'(LOCK_T)) begin
            lock_d = 1'b1;
         end else if (diff > 8'(UNLOCK_T)) begin
            lock_d = 1'b0;
         end
         if (diff <= 8'(TRK_T)) begin
            trk_d = 1'b1;
         end else if (diff > 8'(UNT_T)) begin
            trk_d = 1'b0;
         end
      end
      if (!det_on) begin
         fb_cnt_d = 4'h0;
         win_d    = 8'h00;
         fbw_d    = 8'h00;
         lock_d   = 1'b0;
         trk_d    = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fb_cnt_q <= 4'h0;
         win_q    <= 8'h00;
         fbw_q    <= 8'h00;
         lock_q   <= 1'b0;
         trk_q    <= 1'b0;
      end else begin
         fb_cnt_q <= fb_cnt_d;
         win_q    <= win_d;
         fbw_q    <= fbw_d;
         lock_q   <= lock_d;
         trk_q    <= trk_d;
      end
   end

   // ************************************************************
   // Base clock transition control and divider
   // ************************************************************
   pbc_pkg::pbc_sw_state_type sw_q, sw_d;
   logic       src_vco_q, src_vco_d;
   logic [1:0] xcnt_q, xcnt_d;
   logic [1:0] vcnt_q, vcnt_d;
   logic       div_q, div_d;
   logic       want_vco;
   logic       src_rise;
   logic       vco_done;

   assign want_vco = ctl_q.base_clock_select & range_ok;
   assign src_rise = src_vco_q ? v_rise : x_rise;
   // A stopped VCO cannot supply edges, so its count is waived while it is off.
   assign vco_done = (vcnt_q == pbc_pkg::SWITCH_EDGES) | ~pll_power_on;

   always_comb begin
      sw_d      = sw_q;
      src_vco_d = src_vco_q;
      xcnt_d    = xcnt_q;
      vcnt_d    = vcnt_q;
      div_d     = div_q;
      case (sw_q)
         pbc_pkg::SW_RUN: begin
            if (src_rise) begin
               div_d = ~div_q;
            end
            if (want_vco != src_vco_q) begin
               sw_d   = pbc_pkg::SW_WAIT;
               xcnt_d = 2'h0;
               vcnt_d = 2'h0;
            end
         end
         pbc_pkg::SW_WAIT: begin
            // Output holds its level here, so no partial half period escapes.
            if (x_rise && xcnt_q != pbc_pkg::SWITCH_EDGES) begin
               xcnt_d = xcnt_q + 2'h1;
            end
            if (v_rise && vcnt_q != pbc_pkg::SWITCH_EDGES) begin
               vcnt_d = vcnt_q + 2'h1;
            end
            if (xcnt_q == pbc_pkg::SWITCH_EDGES && vco_done) begin
               src_vco_d = want_vco;
               sw_d      = pbc_pkg::SW_RUN;
            end
         end
         default: begin
            sw_d = pbc_pkg::SW_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_q      <= pbc_pkg::SW_RUN;
         src_vco_q <= 1'b0;
         xcnt_q    <= 2'h0;
         vcnt_q    <= 2'h0;
         div_q     <= 1'b0;
      end else begin
         sw_q      <= sw_d;
         src_vco_q <= src_vco_d;
         xcnt_q    <= xcnt_d;
         vcnt_q    <= vcnt_d;
         div_q     <= div_d;
      end
   end

   assign base_clock_out = div_q;

endmodule // pbc_top

/* File: rtl/unused_placeholder_none.sv */
// Purpose: Reserved; the clock control logic lives entirely in pbc_top.
// Assumes: Nothing.
// Notes:   Holds no module, so nothing here is elaborated.

/* File: verif/pbc_properties.sv */
// Purpose: Port properties of the clock control block.
// Assumes: One clock domain, one bus slave.
// Notes:   Read data loads one edge after the address edge.
`timescale 1ns/1ns
module pbc_properties (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Clock control
   input wire logic        pll_power_on,
   input wire logic [3:0]  vco_range,
   input wire logic [3:0]  feedback_multiplier,
   input wire logic        base_clock_out,
   input wire logic        lock_irq
);
   // ************
   // Properties
   // ************
   logic taken;
   assign taken = hsel && htrans[1] && hready;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_ready; taken && hwrite |=> hreadyout; endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
   property p_rdata; $changed(hrdata) |-> $past(taken && !hwrite, 2); endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved without a read");
   property p_flag_clr; taken && !hwrite && haddr[7:0] == 8'h00 |-> ##2 !lock_irq; endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag kept after read");
   property p_range_off; vco_range == 4'h0 |-> !pll_power_on; endproperty
   a_range_off: assert property (p_range_off) else $error("pll on with zero range");
   property p_mul; feedback_multiplier != 4'h0; endproperty
   a_mul: assert property (p_mul) else $error("multiplier shows zero");
   property p_prog; taken && hwrite && haddr[7:0] == 8'h08 |=> ##1
      vco_range == $past(hwdata[3:0]); endproperty
   a_prog: assert property (p_prog) else $error("range field not taken");
   // Sources are at least four cycles a period, so a shorter level is a runt.
   property p_no_runt; $changed(base_clock_out) |=> $stable(base_clock_out)[*3]; endproperty
   a_no_runt: assert property (p_no_runt) else $error("runt on base clock");
endmodule // pbc_properties

/* File: verif/pbc_analog_model.sv */
// Purpose: Crystal and VCO sources of the far side.
// Assumes: Crystal period 80 ns; locked VCO runs at N times the crystal, but never faster than twice the crystal.
// Notes:   The VCO stands low while the PLL is off.
`timescale 1ns/1ns
module pbc_analog_model (
   // Sources
   output logic            crystal_clock,
   output logic            vco_clock,
   // Controls
   input  wire logic       pll_power_on,
   input  wire logic [3:0] feedback_multiplier,
   input  wire logic       detune
);
   // ************
   // Sources
   // ************
   initial begin
      crystal_clock = 1'b0;
      vco_clock = 1'b0;
      #1;
      forever #40 crystal_clock = ~crystal_clock;
   end
   // Half periods below 20 ns are clamped, as the block cannot sample them.
   always begin : vco_gen
      int h;
      #2;
      if (pll_power_on !== 1'b1) begin
         vco_clock = 1'b0;
      end else begin
         h = detune ? 60 : 40 / feedback_multiplier;
         if (h < 20) begin
            h = 20;
         end
         #(h - 2) vco_clock = ~vco_clock;
      end
   end
endmodule // pbc_analog_model

/* File: verif/pbc_tb_top.sv */
// Purpose: Self-checking bench of the clock control block.
// Assumes: Lock window shortened to 8 crystal edges.
// Notes:   Bus signals move only right after a rising edge.
`timescale 1ns/1ns
module pbc_tb_top;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        crystal_clock;
   logic        vco_clock;
   logic        pll_power_on;
   logic        loop_filter_track;
   logic [3:0]  vco_range;
   logic [3:0]  feedback_multiplier;
   logic        base_clock_out;
   logic        lock_irq;
   logic        detune;
   logic [31:0] rv;
   logic [7:0]  v;
   int          failures = 0;
   int          n_compared = 0;
   always #4 hclk = ~hclk;
   pbc_top #(.WIN(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .crystal_clock(crystal_clock),
      .vco_clock(vco_clock), .pll_power_on(pll_power_on), .loop_filter_track(loop_filter_track),
      .vco_range(vco_range), .feedback_multiplier(feedback_multiplier),
      .base_clock_out(base_clock_out), .lock_irq(lock_irq));
   pbc_analog_model u_analog (.crystal_clock(crystal_clock), .vco_clock(vco_clock),
      .pll_power_on(pll_power_on), .feedback_multiplier(feedback_multiplier), .detune(detune));
   // ************
   // Tasks
   // ************
   task automatic end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Values are taken at the falling edge, i.e. what the next rising edge samples.
   task automatic wait_rdy;
      logic r;
      r = 1'b0;
      for (int n = 0; r !== 1'b1; n++) begin
         @(negedge hclk);
         r = hreadyout;
         rv = hrdata;
         @(posedge hclk);
         if (n > 20) begin
            failures++;
            end_sim();
         end
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00);
      chk(rv, {24'h0, e});
   endtask
   task automatic wait_irq;
      logic r;
      r = 1'b0;
      for (int n = 0; n < 600 && r !== 1'b1; n++) begin
         @(negedge hclk);
         r = lock_irq;
         @(posedge hclk);
      end
      chk({31'h0, r}, 32'h1);
   endtask
   task automatic toggles(input int lo, input int hi);
      int c;
      logic p;
      c = 0;
      // A source change may hold the output for up to three crystal periods.
      repeat (40) @(posedge hclk);
      @(negedge hclk);
      p = base_clock_out;
      repeat (100) begin
         @(negedge hclk);
         c += (base_clock_out !== p);
         p = base_clock_out;
      end
      @(posedge hclk);
      chk({31'h0, c >= lo && c <= hi}, 32'h1);
   endtask
   // ************
   // Tests
   // ************
   initial begin
      #100000;
      failures++;
      end_sim();
   end
   initial begin
      hresetn = 1'b0;
      {hsel, haddr, htrans, hwrite, hwdata, detune} = '0;
      hsize = 3'b010;
      rv = $urandom(32'hccf58f81);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk({20'h0, pll_power_on, loop_filter_track, vco_range, feedback_multiplier,
         base_clock_out, lock_irq}, 32'h844);
      @(posedge hclk);
      rd(8'h00, 8'h2f);
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h11);
      rd(8'h0c, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hf0 : (i == 2) ? 8'h0f : 8'($urandom);
         xfer(8'h08, 1'b1, v);
         rd(8'h08, v);
         @(negedge hclk);
         chk({28'h0, feedback_multiplier}, {28'h0, v[7:4] == 4'h0 ? 4'h1 : v[7:4]});
         chk({28'h0, vco_range}, {28'h0, v[3:0]});
         chk({31'h0, pll_power_on}, {31'h0, v[3:0] != 4'h0});
         @(posedge hclk);
      end
      xfer(8'h08, 1'b1, 8'h20);
      xfer(8'h00, 1'b1, 8'h30);
      rd(8'h00, 8'h2f);
      xfer(8'h08, 1'b1, 8'h27);
      xfer(8'h00, 1'b1, 8'h10);
      rd(8'h00, 8'h0f);
      xfer(8'h00, 1'b1, 8'h30);
      rd(8'h00, 8'h2f);
      xfer(8'h00, 1'b1, 8'h30);
      rd(8'h00, 8'h3f);
      toggles(19, 21);
      xfer(8'h00, 1'b1, 8'h10);
      rd(8'h00, 8'h3f);
      xfer(8'h00, 1'b1, 8'h20);
      toggles(9, 11);
      xfer(8'h04, 1'b1, 8'h80);
      xfer(8'h00, 1'b1, 8'ha0);
      wait_irq();
      rd(8'h04, 8'he0);
      rd(8'h00, 8'hef);
      rd(8'h00, 8'haf);
      @(negedge hclk);
      chk({31'h0, loop_filter_track}, 32'h1);
      @(posedge hclk);
      xfer(8'h00, 1'b1, 8'hb0);
      toggles(19, 21);
      xfer(8'h00, 1'b1, 8'ha0);
      detune <= 1'b1;
      wait_irq();
      // The window that straddles the detune can drop lock before tracking.
      repeat (200) @(posedge hclk);
      rd(8'h04, 8'h80);
      @(negedge hclk);
      chk({31'h0, loop_filter_track}, 32'h0);
      @(posedge hclk);
      detune <= 1'b0;
      xfer(8'h00, 1'b1, 8'h00);
      xfer(8'h04, 1'b1, 8'h00);
      rd(8'h00, 8'h0f);
      xfer(8'h00, 1'b1, 8'h20);
      repeat (50) @(posedge hclk);
      xfer(8'h04, 1'b1, 8'h20);
      rd(8'h04, 8'h20);
      @(negedge hclk);
      chk({30'h0, loop_filter_track, lock_irq}, 32'h2);
      @(posedge hclk);
      repeat (50) @(posedge hclk);
      xfer(8'h00, 1'b1, 8'h30);
      rd(8'h00, 8'h3f);
      end_sim();
   end
endmodule // pbc_tb_top
bind pbc_top pbc_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pll_power_on(pll_power_on),
   .vco_range(vco_range), .feedback_multiplier(feedback_multiplier),
   .base_clock_out(base_clock_out), .lock_irq(lock_irq));
